/* tc16_pkg.sv */
// Package for the 16-bit timer/counter: register map, field layout, modes, prescale codes.
// Assumes every user writes tc16_pkg::name; nothing is imported.
package tc16_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned TC16_DW = 16;
  localparam int unsigned TC16_AW = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] TC16_OFS_CTRL = 4'h0;
  localparam logic [3:0] TC16_OFS_COUNTER = 4'h1;
  localparam logic [3:0] TC16_OFS_COMPARE_A = 4'h2;
  localparam logic [3:0] TC16_OFS_COMPARE_B = 4'h3;
  localparam logic [3:0] TC16_OFS_CAPTURE = 4'h4;
  localparam logic [3:0] TC16_OFS_FLAGS = 4'h5;
  localparam logic [3:0] TC16_OFS_PIN = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TC16_CTRL_WSEL_LSB = 0;
  localparam int unsigned TC16_CTRL_PRESC_LSB = 4;
  localparam int unsigned TC16_CTRL_ACT_A_LSB = 8;
  localparam int unsigned TC16_CTRL_ACT_B_LSB = 10;
  localparam int unsigned TC16_FLAG_OVF = 0;
  localparam int unsigned TC16_FLAG_CMP_A = 1;
  localparam int unsigned TC16_FLAG_CMP_B = 2;
  localparam int unsigned TC16_FLAG_CAPT = 3;
  localparam int unsigned TC16_PIN_DIR_A = 0;
  localparam int unsigned TC16_PIN_DIR_B = 1;
  localparam int unsigned TC16_PIN_PORT_A = 2;
  localparam int unsigned TC16_PIN_PORT_B = 3;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] TC16_RST_VALUE = 16'h0000;
  localparam logic [15:0] TC16_MAX = 16'hFFFF;
  localparam logic [15:0] TC16_TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TC16_TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TC16_TOP_10BIT = 16'h03FF;

  // ----------------------------------------------------------------
  // Waveform select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] TC16_WS_CTC_CMPA = 4'h4;
  localparam logic [3:0] TC16_WS_FAST_8 = 4'h5;
  localparam logic [3:0] TC16_WS_FAST_9 = 4'h6;
  localparam logic [3:0] TC16_WS_FAST_10 = 4'h7;
  localparam logic [3:0] TC16_WS_CTC_CAPT = 4'hC;
  localparam logic [3:0] TC16_WS_FAST_CAPT = 4'hE;
  localparam logic [3:0] TC16_WS_FAST_CMPA = 4'hF;

  // ----------------------------------------------------------------
  // Output actions
  // ----------------------------------------------------------------
  localparam logic [1:0] TC16_ACT_NONE = 2'h0;
  localparam logic [1:0] TC16_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TC16_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TC16_ACT_SET = 2'h3;

  // ----------------------------------------------------------------
  // Prescale select codes and tick masks (divide minus one)
  // ----------------------------------------------------------------
  localparam logic [2:0] TC16_PS_STOP = 3'h0;
  localparam logic [2:0] TC16_PS_DIV1 = 3'h1;
  localparam logic [2:0] TC16_PS_DIV8 = 3'h2;
  localparam logic [2:0] TC16_PS_DIV64 = 3'h3;
  localparam logic [2:0] TC16_PS_DIV256 = 3'h4;
  localparam logic [2:0] TC16_PS_DIV1024 = 3'h5;
  localparam logic [9:0] TC16_MASK_DIV1 = 10'h000;
  localparam logic [9:0] TC16_MASK_DIV8 = 10'h007;
  localparam logic [9:0] TC16_MASK_DIV64 = 10'h03F;
  localparam logic [9:0] TC16_MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] TC16_MASK_DIV1024 = 10'h3FF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } tc16_req_s;

  typedef struct packed {
    logic [1:0] output_action_b;
    logic [1:0] output_action_a;
    logic [2:0] prescale_sel;
    logic [3:0] waveform_select;
  } tc16_ctrl_s;

  typedef struct packed {
    logic port_b;
    logic port_a;
    logic pin_dir_b;
    logic pin_dir_a;
  } tc16_pin_s;

endpackage : tc16_pkg

/* tc16_prescaler.sv */
// Prescaler: turns the I/O clock into one-cycle timer clock enable pulses.
// Assumes sys_clk is the I/O clock and the select comes from a register on the same clock.
`timescale 1ns/1ns
module tc16_prescaler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic [2:0] prescale_sel,
  // Timer clock enable
  output logic tick
);

  logic [9:0] div_q;
  logic [9:0] div_d;
  logic [9:0] tick_mask;
  logic running;

  function automatic logic [9:0] sel_mask(input logic [2:0] sel);
    unique case (sel)
      tc16_pkg::TC16_PS_DIV8: sel_mask = tc16_pkg::TC16_MASK_DIV8;
      tc16_pkg::TC16_PS_DIV64: sel_mask = tc16_pkg::TC16_MASK_DIV64;
      tc16_pkg::TC16_PS_DIV256: sel_mask = tc16_pkg::TC16_MASK_DIV256;
      tc16_pkg::TC16_PS_DIV1024: sel_mask = tc16_pkg::TC16_MASK_DIV1024;
      default: sel_mask = tc16_pkg::TC16_MASK_DIV1;
    endcase
  endfunction : sel_mask

  // Divide by 1, 8, 64, 256 or 1024; other codes stop the timer
  assign running = (prescale_sel >= tc16_pkg::TC16_PS_DIV1) && (prescale_sel <= tc16_pkg::TC16_PS_DIV1024);
  assign tick_mask = sel_mask(prescale_sel);
  assign tick = running && ((div_q & tick_mask) == tick_mask);
  assign div_d = running ? 10'(div_q + 10'h001) : 10'h000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_d;
    end
  end

endmodule : tc16_prescaler

/* tc16_compare_chan.sv */
// One compare channel: compare value with optional buffer, match detect, waveform state.
// Assumes tick, counter and top events come from the timer core on the same clock.
`timescale 1ns/1ns
module tc16_compare_chan #(
  parameter logic IS_CHAN_A = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wr_mask,
  // Timer state
  input wire logic fast_pwm,
  input wire logic toggle_allowed,
  input wire logic [1:0] output_action,
  input wire logic [15:0] counter_value,
  input wire logic tick,
  input wire logic match_block,
  input wire logic wrap,
  // Results
  output logic [15:0] buffer_value,
  output logic [15:0] compare_value,
  output logic match,
  output logic wave_out
);

  logic [15:0] buf_q;
  logic [15:0] act_q;
  logic wave_q;
  logic wave_d;
  logic [15:0] masked;

  assign masked = wr_data & wr_mask;
  assign match = tick && !match_block && (counter_value == act_q);

  // Wrap action is given last so a compare equal to top yields a steady level
  always_comb begin
    wave_d = wave_q;
    if (!fast_pwm) begin
      if (match) begin
        unique case (output_action)
          tc16_pkg::TC16_ACT_TOGGLE: wave_d = !wave_q;
          tc16_pkg::TC16_ACT_CLEAR: wave_d = 1'b0;
          tc16_pkg::TC16_ACT_SET: wave_d = 1'b1;
          tc16_pkg::TC16_ACT_NONE: wave_d = wave_q;
        endcase
      end
    end else begin
      if (match) begin
        unique case (output_action)
          tc16_pkg::TC16_ACT_TOGGLE: wave_d = (IS_CHAN_A && toggle_allowed) ? !wave_q : wave_q;
          tc16_pkg::TC16_ACT_CLEAR: wave_d = 1'b0;
          tc16_pkg::TC16_ACT_SET: wave_d = 1'b1;
          tc16_pkg::TC16_ACT_NONE: wave_d = wave_q;
        endcase
      end
      if (wrap) begin
        if (output_action == tc16_pkg::TC16_ACT_CLEAR) begin
          wave_d = 1'b1;
        end else if (output_action == tc16_pkg::TC16_ACT_SET) begin
          wave_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_q <= tc16_pkg::TC16_RST_VALUE;
      act_q <= tc16_pkg::TC16_RST_VALUE;
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
      if (wr_en) begin
        buf_q <= masked;
      end
      if (wr_en && !fast_pwm) begin
        act_q <= masked;
      end else if (fast_pwm && wrap) begin
        act_q <= buf_q;
      end
    end
  end

  assign buffer_value = buf_q;
  assign compare_value = act_q;
  assign wave_out = wave_q;

endmodule : tc16_compare_chan

/* tc16_timer.sv */
// Top of the 16-bit timer/counter: register port, counter, top select, flags, pin drive.
// Assumes a single-clock register master on sys_clk; reads answer the cycle after the strobe.
`timescale 1ns/1ns
module tc16_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire tc16_pkg::tc16_req_s reg_req,
  output logic [15:0] reg_rdata,
  // Waveform pins
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tc16_pkg::tc16_ctrl_s ctrl_q;
  tc16_pkg::tc16_pin_s pin_q;
  logic [15:0] counter_q;
  logic [15:0] counter_d;
  logic [15:0] capture_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic block_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic pin_a_out_q;
  logic pin_a_oe_q;
  logic pin_b_out_q;
  logic pin_b_oe_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_CTRL);
  wire wr_counter = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_COUNTER);
  wire wr_cmp_a = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_A);
  wire wr_cmp_b = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_B);
  wire wr_capture = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_CAPTURE);
  wire wr_flags = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_FLAGS);
  wire wr_pin = reg_req.we && (reg_req.addr == tc16_pkg::TC16_OFS_PIN);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic is_fast(input logic [3:0] ws);
    is_fast = (ws == tc16_pkg::TC16_WS_FAST_8) || (ws == tc16_pkg::TC16_WS_FAST_9) ||
              (ws == tc16_pkg::TC16_WS_FAST_10) || (ws == tc16_pkg::TC16_WS_FAST_CAPT) ||
              (ws == tc16_pkg::TC16_WS_FAST_CMPA);
  endfunction : is_fast

  function automatic logic [15:0] fixed_mask(input logic [3:0] ws);
    unique case (ws)
      tc16_pkg::TC16_WS_FAST_8: fixed_mask = tc16_pkg::TC16_TOP_8BIT;
      tc16_pkg::TC16_WS_FAST_9: fixed_mask = tc16_pkg::TC16_TOP_9BIT;
      tc16_pkg::TC16_WS_FAST_10: fixed_mask = tc16_pkg::TC16_TOP_10BIT;
      default: fixed_mask = tc16_pkg::TC16_MAX;
    endcase
  endfunction : fixed_mask

  wire [3:0] wsel = ctrl_q.waveform_select;
  wire fast_pwm = is_fast(wsel);
  wire ctc_mode = (wsel == tc16_pkg::TC16_WS_CTC_CMPA) || (wsel == tc16_pkg::TC16_WS_CTC_CAPT);
  wire top_is_cmp_a = (wsel == tc16_pkg::TC16_WS_CTC_CMPA) || (wsel == tc16_pkg::TC16_WS_FAST_CMPA);
  wire top_is_capt = (wsel == tc16_pkg::TC16_WS_CTC_CAPT) || (wsel == tc16_pkg::TC16_WS_FAST_CAPT);
  wire [15:0] cmp_mask = fixed_mask(wsel);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic tick;

  tc16_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .prescale_sel(ctrl_q.prescale_sel),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Top and counter
  // ----------------------------------------------------------------
  logic [15:0] cmp_a_buf;
  logic [15:0] cmp_a_act;
  logic [15:0] cmp_b_buf;
  logic [15:0] cmp_b_act;
  logic match_a;
  logic match_b;
  logic wave_a;
  logic wave_b;
  logic [15:0] top_value;

  // Top is read live, so outside fast PWM mode 15 a top written below the count is passed by
  always_comb begin
    if (top_is_cmp_a) begin
      top_value = cmp_a_act;
    end else if (top_is_capt) begin
      top_value = capture_q;
    end else if (fast_pwm) begin
      top_value = fixed_mask(wsel);
    end else begin
      top_value = tc16_pkg::TC16_MAX;
    end
  end

  // A counter write blocks the top match as well as channel matches
  wire clearing = fast_pwm || ctc_mode;
  wire top_hit = tick && !block_q && clearing && (counter_q == top_value);
  wire max_pass = tick && (counter_q == tc16_pkg::TC16_MAX);
  wire wrap = fast_pwm && top_hit;

  always_comb begin
    if (wr_counter) begin
      counter_d = reg_req.wdata;
    end else if (top_hit) begin
      counter_d = tc16_pkg::TC16_RST_VALUE;
    end else if (tick) begin
      counter_d = 16'(counter_q + 16'h0001);
    end else begin
      counter_d = counter_q;
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  tc16_compare_chan #(
    .IS_CHAN_A(1'b1)
  ) u_chan_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_cmp_a),
    .wr_data(reg_req.wdata),
    .wr_mask(cmp_mask),
    .fast_pwm(fast_pwm),
    .toggle_allowed(wsel == tc16_pkg::TC16_WS_FAST_CMPA),
    .output_action(ctrl_q.output_action_a),
    .counter_value(counter_q),
    .tick(tick),
    .match_block(block_q),
    .wrap(wrap),
    .buffer_value(cmp_a_buf),
    .compare_value(cmp_a_act),
    .match(match_a),
    .wave_out(wave_a)
  );

  tc16_compare_chan #(
    .IS_CHAN_A(1'b0)
  ) u_chan_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_cmp_b),
    .wr_data(reg_req.wdata),
    .wr_mask(cmp_mask),
    .fast_pwm(fast_pwm),
    .toggle_allowed(1'b0),
    .output_action(ctrl_q.output_action_b),
    .counter_value(counter_q),
    .tick(tick),
    .match_block(block_q),
    .wrap(wrap),
    .buffer_value(cmp_b_buf),
    .compare_value(cmp_b_act),
    .match(match_b),
    .wave_out(wave_b)
  );

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire ovf_event = fast_pwm ? wrap : max_pass;
  wire capt_event = top_is_capt && top_hit;
  wire [3:0] flag_set = {capt_event, match_b, match_a, ovf_event};
  wire [3:0] flag_clr = wr_flags ? reg_req.wdata[3:0] : 4'h0;

  // Set beats clear in the same cycle
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Action 1 in fast PWM is a waveform action only for channel A in mode 15
  wire ovr_a = (ctrl_q.output_action_a != tc16_pkg::TC16_ACT_NONE) &&
               !(fast_pwm && (ctrl_q.output_action_a == tc16_pkg::TC16_ACT_TOGGLE) &&
                 (wsel != tc16_pkg::TC16_WS_FAST_CMPA));
  wire ovr_b = (ctrl_q.output_action_b != tc16_pkg::TC16_ACT_NONE) &&
               !(fast_pwm && (ctrl_q.output_action_b == tc16_pkg::TC16_ACT_TOGGLE));
  wire pin_a_d = ovr_a ? wave_a : pin_q.port_a;
  wire pin_b_d = ovr_b ? wave_b : pin_q.port_b;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_req.re) begin
      unique case (reg_req.addr)
        tc16_pkg::TC16_OFS_CTRL: rdata_d = {4'h0, ctrl_q[10:7], 1'b0, ctrl_q[6:0]};
        tc16_pkg::TC16_OFS_COUNTER: rdata_d = counter_q;
        tc16_pkg::TC16_OFS_COMPARE_A: rdata_d = cmp_a_buf;
        tc16_pkg::TC16_OFS_COMPARE_B: rdata_d = cmp_b_buf;
        tc16_pkg::TC16_OFS_CAPTURE: rdata_d = capture_q;
        tc16_pkg::TC16_OFS_FLAGS: rdata_d = {12'h000, flags_q};
        tc16_pkg::TC16_OFS_PIN: rdata_d = {12'h000, pin_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= '0;
      pin_q <= '0;
      capture_q <= tc16_pkg::TC16_RST_VALUE;
      counter_q <= tc16_pkg::TC16_RST_VALUE;
      flags_q <= 4'h0;
      block_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {reg_req.wdata[11:8], reg_req.wdata[6:0]};
      end
      if (wr_pin) begin
        pin_q <= reg_req.wdata[3:0];
      end
      if (wr_capture) begin
        capture_q <= reg_req.wdata;
      end
      counter_q <= counter_d;
      flags_q <= flags_d;
      if (wr_counter) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      pin_a_out_q <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_out_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      pin_a_out_q <= pin_a_d;
      pin_a_oe_q <= pin_q.pin_dir_a;
      pin_b_out_q <= pin_b_d;
      pin_b_oe_q <= pin_q.pin_dir_b;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_a_out = pin_a_out_q;
  assign pin_a_oe = pin_a_oe_q;
  assign pin_b_out = pin_b_out_q;
  assign pin_b_oe = pin_b_oe_q;

endmodule : tc16_timer

/* tc16_timer_checker.sv */
// Checker for the timer top: pin enables, port function, stopped hold, compare masking.
// Assumes it is bound to tc16_timer and sees only that module's ports.
`timescale 1ns/1ns
module tc16_timer_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire tc16_pkg::tc16_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  // Waveform pins
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe
);
  // ----------------------------------------------------------------
  // Shadow of the control, pin and compare registers
  // ----------------------------------------------------------------
  logic [11:0] ctrl_q;
  logic [3:0] pin_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  wire logic wr_pin = reg_req.we && reg_req.addr == tc16_pkg::TC16_OFS_PIN;
  wire logic [3:0] ws = ctrl_q[3:0];
  wire logic [15:0] msk = ws == 4'h5 ? 16'h00FF : ws == 4'h6 ? 16'h01FF : ws == 4'h7 ? 16'h03FF : 16'hFFFF;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= 12'h000;
      pin_q <= 4'h0;
      cmpa_q <= 16'h0000;
      cmpb_q <= 16'h0000;
    end else if (reg_req.we) begin
      if (reg_req.addr == tc16_pkg::TC16_OFS_CTRL) ctrl_q <= reg_req.wdata[11:0];
      if (wr_pin) pin_q <= reg_req.wdata[3:0];
      if (reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_A) cmpa_q <= reg_req.wdata & msk;
      if (reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_B) cmpb_q <= reg_req.wdata & msk;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_oe_a_follows: assert property (wr_pin |-> ##2 pin_a_oe == $past(reg_req.wdata[0], 2))
    else $error("pin a enable does not follow direction bit");
  a_oe_b_follows: assert property (wr_pin |-> ##2 pin_b_oe == $past(reg_req.wdata[1], 2))
    else $error("pin b enable does not follow direction bit");
  a_port_a_func: assert property ($past(ctrl_q[9:8]) == 2'h0 |-> pin_a_out == $past(pin_q[2]))
    else $error("pin a not on port bit with action zero");
  a_port_b_func: assert property ($past(ctrl_q[11:10]) == 2'h0 |-> pin_b_out == $past(pin_q[3]))
    else $error("pin b not on port bit with action zero");
  a_stop_hold_a: assert property ($past(ctrl_q[6:4], 3) == 3'h0 && $past(ctrl_q[6:4], 2) == 3'h0
    && !$past(reg_req.we, 2) |-> $stable(pin_a_out)) else $error("pin a moved while stopped");
  a_stop_hold_b: assert property ($past(ctrl_q[6:4], 3) == 3'h0 && $past(ctrl_q[6:4], 2) == 3'h0
    && !$past(reg_req.we, 2) |-> $stable(pin_b_out)) else $error("pin b moved while stopped");
  a_cmpa_mask: assert property (reg_req.re && reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_A
    |=> reg_rdata == $past(cmpa_q)) else $error("compare a read not masked value");
  a_cmpb_mask: assert property (reg_req.re && reg_req.addr == tc16_pkg::TC16_OFS_COMPARE_B
    |=> reg_rdata == $past(cmpb_q)) else $error("compare b read not masked value");
  c_pin_out: cover property (wr_pin && reg_req.wdata[0]);
  c_rise_a: cover property ($rose(pin_a_out));
  c_rise_b: cover property ($rose(pin_b_out));
endmodule : tc16_timer_checker

bind tc16_timer tc16_timer_checker u_chk (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

/* tc16_load.sv */
// Load on one waveform pin: pulled down when undriven, counts rises and high cycles.
// Assumes the pin pair comes from the timer on sys_clk.
`timescale 1ns/1ns
module tc16_load (
  // Clock
  input wire logic sys_clk,
  // Pin drive
  input wire logic pin_out,
  input wire logic pin_oe,
  // Measurement
  input wire logic clr,
  output logic level,
  output int rises,
  output int highs
);
  logic last_q;
  assign level = pin_oe ? pin_out : 1'b0;
  always_ff @(posedge sys_clk) begin
    last_q <= level;
    rises <= clr ? 0 : rises + int'(level && !last_q);
    highs <= clr ? 0 : highs + int'(level);
  end
endmodule : tc16_load

/* tc16_timer_bench.sv */
// Bench for the timer: register tasks, two pin loads, one task per scenario.
// Assumes tc16_timer, tc16_load and the bound checker are compiled first.
`timescale 1ns/1ns
module tc16_timer_bench;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic sys_clk;
  logic rst;
  logic clr;
  tc16_pkg::tc16_req_s req;
  logic [15:0] rdata;
  logic a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
  int a_r, a_h, b_r, b_h;
  int err_total = 0, n_checks = 0;
  int dv[5] = '{1, 8, 64, 256, 1024};
  logic [15:0] cmp_t[5] = '{16'h0002, 16'h0002, 16'h0000, 16'h0007, 16'h0007};
  logic [1:0] act_t[5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
  int hi_t[5] = '{24, 40, 8, 64, 0};
  int ri_t[5] = '{8, 8, 8, 0, 0};
  tc16_timer dut (.sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out), .pin_b_oe(b_oe));
  tc16_load load_a (.sys_clk(sys_clk), .pin_out(a_out), .pin_oe(a_oe), .clr(clr), .level(a_lvl), .rises(a_r), .highs(a_h));
  tc16_load load_b (.sys_clk(sys_clk), .pin_out(b_out), .pin_oe(b_oe), .clr(clr), .level(b_lvl), .rises(b_r), .highs(b_h));
  always #2 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] ctl(input logic [3:0] m, input logic [2:0] p, input logic [1:0] a, input logic [1:0] b);
    return {4'h0, b, a, 1'b0, p, m};
  endfunction : ctl
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= {a, d, 2'b10};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    req <= {a, 16'h0000, 2'b01};
    @(posedge sys_clk);
    req <= '0;
    #1;
    d = rdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk($sformatf("register %0h", a), v, e);
  endtask : rdc
  task automatic meas(input int settle, input int n, input int er, input int eh);
    repeat (settle) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    chk("pin a rises", 16'(a_r), 16'(er));
    chk("pin a highs", 16'(a_h), 16'(eh));
    @(posedge sys_clk);
  endtask : meas
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdc(4'(i), 16'h0000);
    wr(4'h7, 16'h1234);
    rdc(4'h7, 16'h0000);
    wr(tc16_pkg::TC16_OFS_PIN, 16'h0005);
    meas(2, 16, 0, 16);
    wr(tc16_pkg::TC16_OFS_PIN, 16'h0004);
    meas(2, 16, 0, 0);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_ctc;
    logic [15:0] v;
    wr(tc16_pkg::TC16_OFS_PIN, 16'h0001);
    for (int p = 1; p <= 5; p++) begin
      wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'(p), 2'h1, 2'h0));
      meas(2 * dv[p-1] + 4, 8 * dv[p-1], 4, 4 * dv[p-1]);
    end
    wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'h0002);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h1, 2'h1, 2'h0));
    meas(8, 60, 10, 30);
    rd(tc16_pkg::TC16_OFS_FLAGS, v);
    chk("compare a flag", v & 16'h000B, 16'h0002);
    wr(tc16_pkg::TC16_OFS_CAPTURE, 16'h0003);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'hC, 3'h1, 2'h1, 2'h0));
    wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'h0000);
    meas(8, 64, 8, 32);
    rd(tc16_pkg::TC16_OFS_FLAGS, v);
    chk("capture flag", v & 16'h0008, 16'h0008);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h0, 2'h1, 2'h0));
    wr(tc16_pkg::TC16_OFS_FLAGS, 16'h000F);
    rdc(tc16_pkg::TC16_OFS_FLAGS, 16'h0000);
    rd(tc16_pkg::TC16_OFS_COUNTER, v);
    rdc(tc16_pkg::TC16_OFS_COUNTER, v);
    $display("Test clear on match done");
  endtask : t_ctc
  task automatic t_miss;
    logic [15:0] v;
    wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'h0005);
    wr(tc16_pkg::TC16_OFS_COUNTER, 16'h0005);
    wr(tc16_pkg::TC16_OFS_FLAGS, 16'h000F);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h1, 2'h0, 2'h0));
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h0, 2'h0, 2'h0));
    rd(tc16_pkg::TC16_OFS_FLAGS, v);
    chk("blocked match", v & 16'h0002, 16'h0000);
    wr(tc16_pkg::TC16_OFS_COUNTER, 16'hFFF0);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h1, 2'h0, 2'h0));
    rd(tc16_pkg::TC16_OFS_FLAGS, v);
    chk("missed top", v & 16'h0003, 16'h0000);
    repeat (30) @(posedge sys_clk);
    rd(tc16_pkg::TC16_OFS_FLAGS, v);
    chk("wrap flags", v & 16'h0003, 16'h0003);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'h4, 3'h0, 2'h0, 2'h0));
    $display("Test missed top done");
  endtask : t_miss
  task automatic t_fast;
    logic [15:0] v;
    wr(tc16_pkg::TC16_OFS_PIN, 16'h0003);
    wr(tc16_pkg::TC16_OFS_CAPTURE, 16'h0007);
    for (int i = 0; i < 5; i++) begin
      wr(tc16_pkg::TC16_OFS_COMPARE_A, cmp_t[i]);
      wr(tc16_pkg::TC16_OFS_COMPARE_B, cmp_t[i]);
      wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'hE, 3'h1, act_t[i], act_t[i]));
      if (i == 0) wr(tc16_pkg::TC16_OFS_FLAGS, 16'h000F);
      meas(20, 64, ri_t[i], hi_t[i]);
      chk("pin b highs", 16'(b_h), 16'(hi_t[i]));
    end
    rdc(tc16_pkg::TC16_OFS_FLAGS, 16'h000F);
    wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'h0003);
    wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'hF, 3'h1, 2'h1, 2'h0));
    meas(20, 64, 8, 32);
    wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'h0001);
    meas(20, 64, 16, 32);
    $display("Test fast pwm done");
  endtask : t_fast
  task automatic t_fixed;
    logic [15:0] top;
    for (int i = 0; i < 3; i++) begin
      top = i == 0 ? 16'h00FF : i == 1 ? 16'h01FF : 16'h03FF;
      wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'(5 + i), 3'h0, 2'h2, 2'h0));
      wr(tc16_pkg::TC16_OFS_COMPARE_A, 16'hFFFF);
      rdc(tc16_pkg::TC16_OFS_COMPARE_A, top);
      wr(tc16_pkg::TC16_OFS_COMPARE_B, 16'hFFFF);
      rdc(tc16_pkg::TC16_OFS_COMPARE_B, top);
      wr(tc16_pkg::TC16_OFS_COMPARE_A, top >> 1);
      wr(tc16_pkg::TC16_OFS_CTRL, ctl(4'(5 + i), 3'h1, 2'h2, 2'h0));
      meas(int'(top) + 5, 2 * (int'(top) + 1), 2, int'(top) + 1);
    end
    $display("Test fixed top done");
  endtask : t_fixed
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    results();
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    clr = 1'b0;
    req = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_ctc();
    t_miss();
    t_fast();
    t_fixed();
    results();
  end
endmodule : tc16_timer_bench
